// ==== rtl/swsem_top.sv ====
`timescale 1ns/1ps
`include "swsem_regs.svh"
module swsem_top
  import swsem_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input swsem_pkg::swsem_bus_req_t bus_req_i,
  output logic [31:0] bus_rdata_o,
  input wire logic io_soft_reset_i,
  input wire logic fw_wr_i,
  input wire logic [31:0] fw_wdata_i,
  input wire logic mgmt_clk_gated_i,
  output logic mgmt_clk_ungate_o,
  input wire logic serdes_ack_i,
  output logic serdes_req_o,
  output swsem_pkg::swsem_serdes_word_t serdes_word_o,
  output logic drv_nvm_lock_o,
  output logic fw_lock_o,
  output logic drv_lock_bit_o,
  output swsem_pkg::swsem_ext_err_t fw_ext_err_o
);
  // address decode shared by read and write paths
  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    hit = (a == off);
  endfunction

  wire logic sel_fw = hit(bus_req_i.addr, `SWSEM_OFF_FW_STATUS);
  wire logic sel_sc = hit(bus_req_i.addr, `SWSEM_OFF_SERDES);
  wire logic sel_sw = hit(bus_req_i.addr, `SWSEM_OFF_SW_LOCK);
  wire logic sc_wr = bus_req_i.wr && sel_sc;
  wire logic sw_wr = bus_req_i.wr && sel_sw;
  wire logic sw_rd = bus_req_i.rd && sel_sw;
  wire logic wr_nvm = bus_req_i.wdata[`SWSEM_SW_NVM_LOCK_BIT];
  wire logic wr_drv = bus_req_i.wdata[`SWSEM_SW_DRV_LOCK_BIT];
  wire logic wr_wake = bus_req_i.wdata[`SWSEM_SW_WAKE_BIT];
  // firmware lock requests; one strobe carries either take or release
  wire logic fw_take_req = fw_wr_i && fw_wdata_i[`SWSEM_FW_LOCK_BIT];
  wire logic fw_rel_req = fw_wr_i && !fw_wdata_i[`SWSEM_FW_LOCK_BIT];
  // host nvm lock requests, same split
  wire logic host_take_req = sw_wr && wr_nvm;
  wire logic host_rel_req = sw_wr && !wr_nvm;

  logic sc_done;
  logic wake_bit;
  logic drv_lock_bit;
  swsem_ext_err_t fw_err;

  // serdes configuration access engine
  swsem_serdes_port u_serdes
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .wr_i(sc_wr),
    .wdata_i(bus_req_i.wdata),
    .ack_i(serdes_ack_i),
    .done_o(sc_done),
    .req_o(serdes_req_o),
    .word_o(serdes_word_o)
  );

  // driver/firmware nvm arbitration; firmware can block a host take but never sets or clears the host lock
  swsem_lock_arb u_arb
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .host_set_i(host_take_req),
    .host_clr_i(host_rel_req),
    .fw_set_i(fw_take_req),
    .fw_clr_i(fw_rel_req),
    .soft_rst_i(io_soft_reset_i),
    .drv_lock_o(drv_nvm_lock_o),
    .fw_lock_o(fw_lock_o)
  );

  // driver lock bit: a read sets it, a written 0 clears it, soft reset wins
  wire logic next_drv_lock = io_soft_reset_i ? 1'b0 :
                             sw_rd ? 1'b1 :
                             (sw_wr && !wr_drv) ? 1'b0 : drv_lock_bit;

  // wake request only ungates when the clock is actually gated
  wire logic next_ungate = sw_wr && wr_wake && mgmt_clk_gated_i;
  // wake bit lives one cycle then drops; config-complete lives elsewhere, untouched
  wire logic next_wake = sw_wr && wr_wake && !wake_bit;

  // firmware error field, host can only look at it
  wire swsem_ext_err_t next_err = fw_wr_i ?
    swsem_ext_err_t'(fw_wdata_i[`SWSEM_FW_ERR_MSB:`SWSEM_FW_ERR_LSB]) : fw_err;

  // read data assembly; unmapped reads return zero
  logic [31:0] rd_sc;
  logic [31:0] rd_sw;
  logic [31:0] rd_fw;
  logic [31:0] next_rdata;
  always_comb
  begin
    rd_sc = '0;
    rd_sc[`SWSEM_SC_DONE_BIT] = sc_done;
    rd_sc[`SWSEM_SC_ADDR_MSB:`SWSEM_SC_ADDR_LSB] = serdes_word_o.addr;
    rd_sc[`SWSEM_SC_DATA_MSB:`SWSEM_SC_DATA_LSB] = serdes_word_o.data;
    rd_sw = '0;
    rd_sw[`SWSEM_SW_WAKE_BIT] = wake_bit;
    rd_sw[`SWSEM_SW_NVM_LOCK_BIT] = drv_nvm_lock_o;
    rd_sw[`SWSEM_SW_DRV_LOCK_BIT] = drv_lock_bit;
    rd_fw = '0;
    rd_fw[`SWSEM_FW_ERR_MSB:`SWSEM_FW_ERR_LSB] = fw_err;
    rd_fw[`SWSEM_FW_LOCK_BIT] = fw_lock_o;
  end
  assign next_rdata = !bus_req_i.rd ? 32'h00000000 :
                      sel_sc ? rd_sc :
                      sel_sw ? rd_sw :
                      sel_fw ? rd_fw : 32'h00000000;

  // read data registered so the answer stands exactly one cycle
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bus_rdata_o <= 32'h00000000;
    end
    else
    begin
      bus_rdata_o <= next_rdata;
    end
  end

  // driver lock bit, set by reads, cleared by a written zero
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      drv_lock_bit <= 1'b0;
    end
    else
    begin
      drv_lock_bit <= next_drv_lock;
    end
  end

  // wake bit and ungate pulse together: wake bit lives one cycle, ungate stays high across back-to-back gated wake writes
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wake_bit <= 1'b0;
      mgmt_clk_ungate_o <= 1'b0;
    end
    else
    begin
      wake_bit <= next_wake;
      mgmt_clk_ungate_o <= next_ungate;
    end
  end

  // firmware error field; only the firmware strobe loads it
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      fw_err <= SWSEM_EE_NONE;
    end
    else
    begin
      fw_err <= next_err;
    end
  end

  assign drv_lock_bit_o = drv_lock_bit;
  assign fw_ext_err_o = fw_err;

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_done_clears_write: assert property (sc_wr |=> !sc_done)
    else $error("serdes done did not clear on write");

  a_done_sets_ack: assert property (
    (!sc_done && !sc_wr && serdes_ack_i) |=> sc_done)
    else $error("serdes done did not set after completion");

  a_done_holds_busy: assert property (
    sc_wr ##1 (!serdes_ack_i && !sc_wr)[*2] |=> !sc_done)
    else $error("serdes done rose without completion");

  a_wake_self_clear: assert property (wake_bit |=> !wake_bit)
    else $error("wake bit did not clear itself");

  a_ungate_cause: assert property (
    $rose(mgmt_clk_ungate_o) |-> $past(sw_wr && wr_wake && mgmt_clk_gated_i))
    else $error("ungate without a wake request on gated clock");

  a_ungate_on_wake: assert property (
    (sw_wr && wr_wake && mgmt_clk_gated_i) |=> mgmt_clk_ungate_o)
    else $error("wake request did not ungate clock");

  a_nvm_lock_blocked: assert property (
    (sw_wr && wr_nvm && fw_lock_o) |=> !drv_nvm_lock_o)
    else $error("host took nvm lock while firmware holds it");

  a_locks_exclusive: assert property (!(drv_nvm_lock_o && fw_lock_o))
    else $error("both nvm locks granted");

  a_nvm_soft_reset: assert property (io_soft_reset_i |=> !drv_nvm_lock_o && !drv_lock_bit)
    else $error("soft reset left a driver lock set");

  a_read_sets_lock: assert property (
    (sw_rd && !io_soft_reset_i) |=> drv_lock_bit ##1 (drv_lock_bit || $past(io_soft_reset_i) ||
      $past(sw_wr && !wr_drv)))
    else $error("read did not set driver lock bit");

  a_first_read_zero: assert property (
    (sw_rd && !drv_lock_bit) |=> !bus_rdata_o[`SWSEM_SW_DRV_LOCK_BIT])
    else $error("first read of free lock did not return zero");

  a_later_read_one: assert property (
    (sw_rd && drv_lock_bit) |=> bus_rdata_o[`SWSEM_SW_DRV_LOCK_BIT])
    else $error("held lock read back as zero");

  a_write_one_keeps: assert property (
    (sw_wr && wr_drv && drv_lock_bit && !io_soft_reset_i) |=> drv_lock_bit)
    else $error("writing one cleared driver lock");

  a_write_zero_clears: assert property (
    (sw_wr && !wr_drv && !io_soft_reset_i) |=> !drv_lock_bit)
    else $error("writing zero left driver lock set");

  a_err_field_load: assert property (
    fw_wr_i |=> fw_err == $past(fw_wdata_i[`SWSEM_FW_ERR_MSB:`SWSEM_FW_ERR_LSB]))
    else $error("error field did not take firmware value");

  a_fw_lock_take: assert property (
    (fw_wr_i && fw_wdata_i[`SWSEM_FW_LOCK_BIT] && !drv_nvm_lock_o) |=> fw_lock_o)
    else $error("firmware lock not granted while free");

  a_host_lock_take: assert property (
    (sw_wr && wr_nvm && !fw_lock_o && !(fw_wr_i && fw_wdata_i[`SWSEM_FW_LOCK_BIT])
      && !io_soft_reset_i) |=> drv_nvm_lock_o)
    else $error("host nvm lock not granted while free");

  // register and read-view checks; done low means the engine is busy
  a_done_stable_idle: assert property (
    (!sc_wr && !serdes_ack_i) |=> $stable(sc_done))
    else $error("serdes done moved with no write or completion");

  a_req_on_write: assert property (
    sc_wr |=> serdes_req_o)
    else $error("serdes request missing after write");

  a_req_single_pulse: assert property (
    !sc_wr |=> !serdes_req_o)
    else $error("serdes request without a write");

  a_word_latched: assert property (
    sc_wr |=> (serdes_word_o == $past(bus_req_i.wdata[`SWSEM_SC_ADDR_MSB:`SWSEM_SC_DATA_LSB])))
    else $error("serdes word did not take written value");

  a_word_holds: assert property (
    !sc_wr |=> $stable(serdes_word_o))
    else $error("serdes word changed without a write");

  a_done_read_view: assert property (
    (bus_req_i.rd && sel_sc) |=> (bus_rdata_o[`SWSEM_SC_DONE_BIT] == $past(sc_done)))
    else $error("serdes read shows wrong done flag");

  a_no_ungate_free: assert property (
    (sw_wr && wr_wake && !mgmt_clk_gated_i) |=> !mgmt_clk_ungate_o)
    else $error("ungate pulse while clock was running");

  a_wake_from_write: assert property (
    wake_bit |-> $past(sw_wr && wr_wake))
    else $error("wake bit set without a write");

  a_wake_read_view: assert property (
    sw_rd |=> (bus_rdata_o[`SWSEM_SW_WAKE_BIT] == $past(wake_bit)))
    else $error("wake bit read back wrong");

  a_nvm_host_only: assert property (
    $rose(drv_nvm_lock_o) |-> $past(host_take_req))
    else $error("nvm lock set without a host write");

  a_nvm_lock_holds: assert property (
    (drv_nvm_lock_o && !host_rel_req && !io_soft_reset_i) |=> drv_nvm_lock_o)
    else $error("nvm lock dropped without host release");

  a_nvm_read_view: assert property (
    sw_rd |=> (bus_rdata_o[`SWSEM_SW_NVM_LOCK_BIT] == $past(drv_nvm_lock_o)))
    else $error("nvm lock read back wrong");

  a_nvm_release: assert property (
    host_rel_req |=> !drv_nvm_lock_o)
    else $error("host release left nvm lock set");

  a_lock_bit_rise: assert property (
    $rose(drv_lock_bit) |-> $past(sw_rd))
    else $error("driver lock bit set without a read");

  a_lock_bit_fall: assert property (
    $fell(drv_lock_bit) |-> $past(io_soft_reset_i || (sw_wr && !wr_drv)))
    else $error("driver lock bit cleared without cause");

  a_fw_lock_rise: assert property (
    $rose(fw_lock_o) |-> $past(fw_take_req))
    else $error("firmware lock set without a take");

  a_fw_lock_release: assert property (
    fw_rel_req |=> !fw_lock_o)
    else $error("firmware release left lock set");

  a_fw_take_blocked: assert property (
    (fw_take_req && drv_nvm_lock_o) |=> !fw_lock_o)
    else $error("firmware took lock held by host");

  a_fw_wins_tie: assert property (
    (host_take_req && fw_take_req && !drv_nvm_lock_o && !fw_lock_o) |=> (fw_lock_o && !drv_nvm_lock_o))
    else $error("same-cycle take not granted to firmware");

  a_fw_soft_keeps: assert property (
    (io_soft_reset_i && fw_lock_o && !fw_rel_req) |=> fw_lock_o)
    else $error("soft reset cleared firmware lock");

  a_err_holds: assert property (
    !fw_wr_i |=> $stable(fw_err))
    else $error("error field changed without firmware write");

  a_fw_read_view: assert property (
    (bus_req_i.rd && sel_fw) |=> (bus_rdata_o[`SWSEM_FW_ERR_MSB:`SWSEM_FW_ERR_LSB] == $past(fw_err)))
    else $error("error field read back wrong");

  a_fw_lock_view: assert property (
    (bus_req_i.rd && sel_fw) |=> (bus_rdata_o[`SWSEM_FW_LOCK_BIT] == $past(fw_lock_o)))
    else $error("firmware lock read back wrong");

  c_serdes_round: cover property (sc_wr ##[1:20] sc_done);
  c_lock_tie: cover property (sw_wr && wr_nvm && fw_wr_i && fw_wdata_i[`SWSEM_FW_LOCK_BIT]);
  c_read_twice: cover property (sw_rd ##[1:4] sw_rd);
  c_wake_gated: cover property (mgmt_clk_ungate_o);
  c_soft_reset_held: cover property (io_soft_reset_i && drv_nvm_lock_o);
endmodule

// ==== shared/swsem_regs.svh ====
`ifndef SWSEM_REGS_SVH
`define SWSEM_REGS_SVH

// register byte offsets on the host port
`define SWSEM_OFF_FW_STATUS 16'h0B54
`define SWSEM_OFF_SERDES 16'h5B4C
`define SWSEM_OFF_SW_LOCK 16'h5B50

// serdes_config_access fields
`define SWSEM_SC_DONE_BIT 31
`define SWSEM_SC_ADDR_MSB 15
`define SWSEM_SC_ADDR_LSB 8
`define SWSEM_SC_DATA_MSB 7
`define SWSEM_SC_DATA_LSB 0
`define SWSEM_SC_DONE_RST 1'b1

// software_lock_control fields
`define SWSEM_SW_WAKE_BIT 2
`define SWSEM_SW_NVM_LOCK_BIT 1
`define SWSEM_SW_DRV_LOCK_BIT 0

// firmware_status_and_lock fields
`define SWSEM_FW_ERR_MSB 24
`define SWSEM_FW_ERR_LSB 19
`define SWSEM_FW_LOCK_BIT 0
`define SWSEM_FW_ERR_RST 6'h00

// external error codes
`define SWSEM_ERR_NONE 6'h00
`define SWSEM_ERR_MNG_CSUM 6'h01
`define SWSEM_ERR_PROT_OFF 6'h02
`define SWSEM_ERR_CLK_OFF 6'h03
`define SWSEM_ERR_FLASH_HDR 6'h04
`define SWSEM_ERR_PATCH_CSUM 6'h05
`define SWSEM_ERR_LOADER_CSUM 6'h06
`define SWSEM_ERR_DIAG_CSUM 6'h07
`define SWSEM_ERR_BAD_MODE 6'h08

`endif

// ==== shared/swsem_pkg.sv ====
package swsem_pkg;
`include "swsem_regs.svh"

  // host register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } swsem_bus_req_t;

  // word the serdes access engine hands to the serdes
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } swsem_serdes_word_t;

  // firmware external error causes
  typedef enum logic [5:0] {
    SWSEM_EE_NONE = `SWSEM_ERR_NONE,
    SWSEM_EE_MNG_CSUM = `SWSEM_ERR_MNG_CSUM,
    SWSEM_EE_PROT_OFF = `SWSEM_ERR_PROT_OFF,
    SWSEM_EE_CLK_OFF = `SWSEM_ERR_CLK_OFF,
    SWSEM_EE_FLASH_HDR = `SWSEM_ERR_FLASH_HDR,
    SWSEM_EE_PATCH_CSUM = `SWSEM_ERR_PATCH_CSUM,
    SWSEM_EE_LOADER_CSUM = `SWSEM_ERR_LOADER_CSUM,
    SWSEM_EE_DIAG_CSUM = `SWSEM_ERR_DIAG_CSUM,
    SWSEM_EE_BAD_MODE = `SWSEM_ERR_BAD_MODE
  } swsem_ext_err_t;

  // serdes engine state
  typedef enum logic {
    SWSEM_SC_IDLE,
    SWSEM_SC_BUSY
  } swsem_sc_state_t;
endpackage

// ==== rtl/swsem_serdes_port.sv ====
`timescale 1ns/1ps
`include "swsem_regs.svh"
module swsem_serdes_port
  import swsem_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic [31:0] wdata_i,
  input wire logic ack_i,
  output logic done_o,
  output logic req_o,
  output swsem_pkg::swsem_serdes_word_t word_o
);
  swsem_sc_state_t state;
  swsem_sc_state_t next_state;
  logic next_done;
  wire logic ack_hit = ack_i && (state == SWSEM_SC_BUSY);

  // new data clears done even if the old transfer ends now: the new one is pending
  assign next_done = wr_i ? 1'b0 : (ack_hit ? 1'b1 : done_o);

  always_comb
  begin
    case (state)
      SWSEM_SC_IDLE: next_state = wr_i ? SWSEM_SC_BUSY : SWSEM_SC_IDLE;
      SWSEM_SC_BUSY: next_state = (ack_hit && !wr_i) ? SWSEM_SC_IDLE : SWSEM_SC_BUSY;
      default: next_state = SWSEM_SC_IDLE;
    endcase
  end

  // request pulse and latched word toward the serdes
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= SWSEM_SC_IDLE;
      done_o <= `SWSEM_SC_DONE_RST;
      req_o <= 1'b0;
      word_o <= '0;
    end
    else
    begin
      state <= next_state;
      done_o <= next_done;
      req_o <= wr_i;
      if (wr_i)
      begin
        word_o.addr <= wdata_i[`SWSEM_SC_ADDR_MSB:`SWSEM_SC_ADDR_LSB];
        word_o.data <= wdata_i[`SWSEM_SC_DATA_MSB:`SWSEM_SC_DATA_LSB];
      end
    end
  end
endmodule

// ==== rtl/swsem_lock_arb.sv ====
`timescale 1ns/1ps
module swsem_lock_arb
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic host_set_i,
  input wire logic host_clr_i,
  input wire logic fw_set_i,
  input wire logic fw_clr_i,
  input wire logic soft_rst_i,
  output logic drv_lock_o,
  output logic fw_lock_o
);
  // firmware wins a same-cycle tie; the management side cannot retry cheaply
  wire logic fw_take = fw_set_i && !drv_lock_o;
  wire logic host_take = host_set_i && !fw_lock_o && !fw_take;
  wire logic next_drv = soft_rst_i ? 1'b0 : (host_take ? 1'b1 : (host_clr_i ? 1'b0 : drv_lock_o));
  wire logic next_fw = fw_take ? 1'b1 : (fw_clr_i ? 1'b0 : fw_lock_o);

  // both lock flops
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      drv_lock_o <= 1'b0;
      fw_lock_o <= 1'b0;
    end
    else
    begin
      drv_lock_o <= next_drv;
      fw_lock_o <= next_fw;
    end
  end
endmodule

// ==== test/swsem_testbench.sv ====
`timescale 1ns/1ps
`include "swsem_regs.svh"
module testbench;
  import swsem_pkg::*;
  logic clk_i;
  logic rst_n_i;
  swsem_bus_req_t bus_req_i;
  logic [31:0] bus_rdata_o;
  logic io_soft_reset_i;
  logic fw_wr_i;
  logic [31:0] fw_wdata_i;
  logic mgmt_clk_gated_i;
  logic mgmt_clk_ungate_o;
  logic serdes_ack_i;
  logic serdes_req_o;
  swsem_serdes_word_t serdes_word_o;
  logic drv_nvm_lock_o;
  logic fw_lock_o;
  logic drv_lock_bit_o;
  swsem_ext_err_t fw_ext_err_o;
  logic [31:0] rd_q;
  int err_total;
  int total_checks;

  swsem_top i_swsem_top (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .bus_req_i(bus_req_i),
    .bus_rdata_o(bus_rdata_o),
    .io_soft_reset_i(io_soft_reset_i),
    .fw_wr_i(fw_wr_i),
    .fw_wdata_i(fw_wdata_i),
    .mgmt_clk_gated_i(mgmt_clk_gated_i),
    .mgmt_clk_ungate_o(mgmt_clk_ungate_o),
    .serdes_ack_i(serdes_ack_i),
    .serdes_req_o(serdes_req_o),
    .serdes_word_o(serdes_word_o),
    .drv_nvm_lock_o(drv_nvm_lock_o),
    .fw_lock_o(fw_lock_o),
    .drv_lock_bit_o(drv_lock_bit_o),
    .fw_ext_err_o(fw_ext_err_o)
  );

  // 10 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one-cycle write; returns at the sampling edge
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus_req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus_req_i <= '0;
  endtask

  // read data are captured in the one cycle they stand
  task automatic rd(input logic [15:0] a);
    @(posedge clk_i);
    bus_req_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus_req_i <= '0;
    #1;
    rd_q = bus_rdata_o;
  endtask

  task automatic fw(input logic [31:0] d);
    @(posedge clk_i);
    fw_wr_i <= 1'b1;
    fw_wdata_i <= d;
    @(posedge clk_i);
    fw_wr_i <= 1'b0;
    #1;
  endtask

  // watchdog so a hang still ends in the verdict
  initial
  begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    end_sim();
  end

  initial
  begin
    err_total = 0;
    total_checks = 0;
    rst_n_i = 1'b0;
    bus_req_i = '0;
    io_soft_reset_i = 1'b0;
    fw_wr_i = 1'b0;
    fw_wdata_i = 32'h0;
    mgmt_clk_gated_i = 1'b0;
    serdes_ack_i = 1'b0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // done flag high out of reset, unmapped address reads zero
    rd(`SWSEM_OFF_SERDES);
    chk(32'(rd_q[31]), 32'h1);
    rd(16'h0000);
    chk(rd_q, 32'h0);
    // read-to-set driver lock: 0 first, then 1; writing 1 keeps it
    rd(`SWSEM_OFF_SW_LOCK);
    chk(32'(rd_q[0]), 32'h0);
    chk(32'(drv_lock_bit_o), 32'h1);
    rd(`SWSEM_OFF_SW_LOCK);
    chk(32'(rd_q[0]), 32'h1);
    wr(`SWSEM_OFF_SW_LOCK, 32'h1);
    #1;
    chk(32'(drv_lock_bit_o), 32'h1);
    wr(`SWSEM_OFF_SW_LOCK, 32'h0);
    #1;
    chk(32'(drv_lock_bit_o), 32'h0);
    // serdes write clears done until the far end acknowledges
    wr(`SWSEM_OFF_SERDES, 32'h0000_1234);
    #1;
    chk(32'(serdes_req_o), 32'h1);
    chk(32'(serdes_word_o), 32'h0000_1234);
    rd(`SWSEM_OFF_SERDES);
    chk(32'(rd_q[31]), 32'h0);
    chk(rd_q, 32'h0000_1234);
    @(posedge clk_i);
    serdes_ack_i <= 1'b1;
    @(posedge clk_i);
    serdes_ack_i <= 1'b0;
    rd(`SWSEM_OFF_SERDES);
    chk(32'(rd_q[31]), 32'h1);
    // wake pulse only when gated, bit reads back cleared
    @(posedge clk_i);
    mgmt_clk_gated_i <= 1'b1;
    wr(`SWSEM_OFF_SW_LOCK, 32'h4);
    #1;
    chk(32'(mgmt_clk_ungate_o), 32'h1);
    @(posedge clk_i);
    #1;
    chk(32'(mgmt_clk_ungate_o), 32'h0);
    rd(`SWSEM_OFF_SW_LOCK);
    chk(32'(rd_q[2]), 32'h0);
    @(posedge clk_i);
    mgmt_clk_gated_i <= 1'b0;
    wr(`SWSEM_OFF_SW_LOCK, 32'h4);
    #1;
    chk(32'(mgmt_clk_ungate_o), 32'h0);
    // firmware holds the lock: host take has no effect
    fw(32'h0008_0001);
    chk(32'(fw_lock_o), 32'h1);
    chk(32'(fw_ext_err_o), 32'h1);
    wr(`SWSEM_OFF_SW_LOCK, 32'h2);
    #1;
    chk(32'(drv_nvm_lock_o), 32'h0);
    fw(32'h0);
    chk(32'(fw_lock_o), 32'h0);
    wr(`SWSEM_OFF_SW_LOCK, 32'h2);
    rd(`SWSEM_OFF_SW_LOCK);
    chk(32'(rd_q[1]), 32'h1);
    fw(32'h1);
    chk(32'(fw_lock_o), 32'h0);
    chk(32'(drv_nvm_lock_o), 32'h1);
    fw(32'h0);
    chk(32'(drv_nvm_lock_o), 32'h1);
    wr(`SWSEM_OFF_SW_LOCK, 32'h0);
    #1;
    chk(32'(drv_nvm_lock_o), 32'h0);
    // same-cycle take: exactly one side wins
    @(posedge clk_i);
    bus_req_i <= '{addr: `SWSEM_OFF_SW_LOCK, wdata: 32'h2, wr: 1'b1, rd: 1'b0};
    fw_wr_i <= 1'b1;
    fw_wdata_i <= 32'h1;
    @(posedge clk_i);
    bus_req_i <= '0;
    fw_wr_i <= 1'b0;
    #1;
    chk(32'(drv_nvm_lock_o) + 32'(fw_lock_o), 32'h1);
    fw(32'h0);
    // every error code lands in bits 24:19
    for (int i = 0; i <= 8; i++)
    begin
      fw({7'h00, 6'(i), 19'h0});
      rd(`SWSEM_OFF_FW_STATUS);
      chk(32'(rd_q[24:19]), 32'(i));
      chk(32'(fw_ext_err_o), 32'(i));
    end
    // host cannot write the firmware register
    wr(`SWSEM_OFF_FW_STATUS, 32'h0100_0001);
    #1;
    chk(32'(fw_lock_o), 32'h0);
    chk(32'(fw_ext_err_o), 32'h8);
    // soft reset drops both host locks, leaves firmware error
    wr(`SWSEM_OFF_SW_LOCK, 32'h2);
    rd(`SWSEM_OFF_SW_LOCK);
    chk(32'(drv_nvm_lock_o), 32'h1);
    @(posedge clk_i);
    io_soft_reset_i <= 1'b1;
    @(posedge clk_i);
    io_soft_reset_i <= 1'b0;
    #1;
    chk(32'(drv_nvm_lock_o), 32'h0);
    chk(32'(drv_lock_bit_o), 32'h0);
    chk(32'(fw_ext_err_o), 32'h8);
    rd(`SWSEM_OFF_SW_LOCK);
    chk(32'(rd_q[1:0]), 32'h0);
    end_sim();
  end
endmodule
